// ==== core/dprm_pkg.sv ====
package dprm_pkg;

    // ----------------------------------------
    // Port geometry
    // ----------------------------------------
    localparam int ADDR_GRP_W = 8;
    localparam int ADDR_W     = 16;
    localparam int MASK_W     = 8;
    localparam int LANE_W     = 9;
    localparam int DATA_W     = 72;
    localparam int PIN_GRP_W  = 12;
    localparam int SP_MAX_BITS = 2048;
    localparam int MEM_DEPTH  = 16;

    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [MASK_W-1:0] MASK_RST = 8'hff;
    localparam logic [DATA_W-1:0] DATA_RST = 72'h00_0000_0000_0000_0000;

    // ----------------------------------------
    // Clocking schemes
    // ----------------------------------------
    typedef enum logic [2:0] {
        MODE_IND,
        MODE_IO_TDP,
        MODE_IO_SDP,
        MODE_RW,
        MODE_SP,
        MODE_SP2
    } dprm_mode_t;

endpackage : dprm_pkg

// ==== core/dprm_port.sv ====
module dprm_port #(
    parameter int IDX_W = 4
) (
    // Clock and reset
    input  wire logic                        mclk,
    input  wire logic                        rst_n,
    input  wire logic                        ce,
    // Register group controls
    input  wire logic                        in_go,
    input  wire logic                        out_go,
    input  wire logic                        clr_in,
    input  wire logic                        clr_out,
    input  wire logic                        bypass,
    input  wire logic                        use_rden,
    input  wire logic                        can_wr,
    // User side
    input  wire logic [IDX_W-1:0]            idx,
    input  wire logic                        wsel,
    input  wire logic [dprm_pkg::MASK_W-1:0] mask,
    input  wire logic [dprm_pkg::DATA_W-1:0] din,
    input  wire logic                        rden,
    output logic      [dprm_pkg::DATA_W-1:0] dout,
    // Array side
    input  wire logic [dprm_pkg::DATA_W-1:0] mem_word,
    output logic      [IDX_W-1:0]            wr_idx,
    output logic      [dprm_pkg::MASK_W-1:0] wr_lanes,
    output logic      [dprm_pkg::DATA_W-1:0] wr_data
);

    logic [IDX_W-1:0]            idx_q, next_idx_q;
    logic                        wsel_q, next_wsel_q;
    logic [dprm_pkg::MASK_W-1:0] mask_q, next_mask_q;
    logic [dprm_pkg::DATA_W-1:0] din_q, next_din_q;
    logic                        op_q, next_op_q;
    logic                        rden_q, next_rden_q;
    logic [dprm_pkg::DATA_W-1:0] rdata, next_rdata;
    logic [dprm_pkg::DATA_W-1:0] oreg, next_oreg;

    // ----------------------------------------
    // Input, read and output groups
    // ----------------------------------------
    always_comb begin
        next_idx_q  = idx_q;
        next_wsel_q = wsel_q;
        next_mask_q = mask_q;
        next_din_q  = din_q;
        next_op_q   = 1'b0;
        next_rdata  = rdata;
        next_rden_q = in_go ? rden : rden_q;
        if (clr_in) begin
            next_idx_q  = '0;
            next_wsel_q = 1'b0;
            next_mask_q = dprm_pkg::MASK_RST;
            next_din_q  = dprm_pkg::DATA_RST;
            next_rdata  = dprm_pkg::DATA_RST;
        end else begin
            if (in_go) begin
                next_idx_q  = idx;
                next_wsel_q = wsel;
                next_mask_q = mask;
                next_din_q  = din;
                next_op_q   = 1'b1;
            end
            if (op_q && (!use_rden || rden_q)) begin
                next_rdata = mem_word;
            end
        end
        next_oreg = oreg;
        if (clr_out) begin
            next_oreg = dprm_pkg::DATA_RST;
        end else if (out_go) begin
            next_oreg = rdata;
        end
    end

    // Clock enable gates the register clears too; registers clear only while ce is high, and clr_out zeroes dout whatever ce is
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            idx_q  <= '0;
            wsel_q <= 1'b0;
            mask_q <= dprm_pkg::MASK_RST;
            din_q  <= dprm_pkg::DATA_RST;
            op_q   <= 1'b0;
            rden_q <= 1'b0;
            rdata  <= dprm_pkg::DATA_RST;
            oreg   <= dprm_pkg::DATA_RST;
        end else if (ce) begin
            idx_q  <= next_idx_q;
            wsel_q <= next_wsel_q;
            mask_q <= next_mask_q;
            din_q  <= next_din_q;
            op_q   <= next_op_q;
            rden_q <= next_rden_q;
            rdata  <= next_rdata;
            oreg   <= next_oreg;
        end
    end

    assign wr_idx   = idx_q;
    assign wr_data  = din_q;
    assign wr_lanes = (op_q && wsel_q && can_wr && !clr_in) ? mask_q : '0;
    assign dout     = clr_out ? dprm_pkg::DATA_RST : (bypass ? rdata : oreg);

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_out_clear_zero: assert property (@(posedge mclk) disable iff (!rst_n)
        clr_out |-> dout == dprm_pkg::DATA_RST)
        else $error("cleared output not zero");

    chk_out_reg_load: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && out_go && !clr_out && !bypass) ##1 (!clr_out && !bypass)
        |-> dout == $past(rdata))
        else $error("output register missed its load");

    chk_rden_no_clear: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && clr_in && !in_go) |=> $stable(rden_q))
        else $error("read enable register was cleared");

    chk_write_needs_sel: assert property (@(posedge mclk) disable iff (!rst_n)
        (wr_lanes != '0) |-> (wsel_q && can_wr && $past(ce && in_go && wsel)))
        else $error("write without write select");

    chk_input_hold: assert property (@(posedge mclk) disable iff (!rst_n)
        (!(ce && (in_go || clr_in))) |=> ($stable(idx_q) && $stable(din_q)))
        else $error("input register moved without its clock");

endmodule : dprm_port

// ==== core/dprm_ram.sv ====
// How it works
// - Independent mode: each port own clock
// - Port registers follow their own port clock
// - Per-port clock enable and clear, independent
// - Independent mode offered for true dual-port
// - Input/output mode for true and simple
// - First clock takes data, write, address
// - Second clock drives only output registers
// - Input and output groups: own enable, clear
// - Read-enable register has no clear
// - Read/write mode: simple dual-port, two clocks
// - Write clock registers write data, address, enable
// - Read clock registers address, enable, output
// - Read and write sides: own enable, clear
// - Single-port mode with one shared port
// - Two single-port memories, each within 2K bits
// - Port pins: address, mask, select, clocks, data
// - Write needs select and lane mask bit
// - Write select chooses read or write
// - Inputs share a clock; output bypassable
module dprm_ram #(
    parameter int MEM_DEPTH = dprm_pkg::MEM_DEPTH
) (
    // Clock, reset, enable
    input  wire logic                          mclk,
    input  wire logic                          resetn,
    input  wire logic                          ce,
    input  wire dprm_pkg::dprm_mode_t          mode,
    // Port A clocks, enables, clears
    input  wire logic                          a_clk,
    input  wire logic                          a_clken,
    input  wire logic                          a_clr,
    input  wire logic                          a_clk2,
    input  wire logic                          a_clken2,
    input  wire logic                          a_clr2,
    input  wire logic                          a_bypass,
    // Port A data path
    input  wire logic [dprm_pkg::ADDR_GRP_W-1:0] a_addr_hi,
    input  wire logic [dprm_pkg::ADDR_GRP_W-1:0] a_addr_lo,
    input  wire logic [dprm_pkg::MASK_W-1:0]   a_byte_mask,
    input  wire logic                          a_wsel,
    input  wire logic [dprm_pkg::DATA_W-1:0]   a_din,
    output logic      [dprm_pkg::DATA_W-1:0]   a_dout,
    // Port B clocks, enables, clears
    input  wire logic                          b_clk,
    input  wire logic                          b_clken,
    input  wire logic                          b_clr,
    input  wire logic                          b_clk2,
    input  wire logic                          b_clken2,
    input  wire logic                          b_clr2,
    input  wire logic                          b_bypass,
    // Port B data path
    input  wire logic [dprm_pkg::ADDR_GRP_W-1:0] b_addr_hi,
    input  wire logic [dprm_pkg::ADDR_GRP_W-1:0] b_addr_lo,
    input  wire logic [dprm_pkg::MASK_W-1:0]   b_byte_mask,
    input  wire logic                          b_wsel,
    input  wire logic                          b_rden,
    input  wire logic [dprm_pkg::DATA_W-1:0]   b_din,
    output logic      [dprm_pkg::DATA_W-1:0]   b_dout
);

    localparam int IDX_W = $clog2(MEM_DEPTH);

    // ----------------------------------------
    // Reset release
    // ----------------------------------------
    logic rst_q1;
    logic rst_n;

    always_ff @(posedge mclk or negedge resetn) begin
        if (!resetn) begin
            rst_q1 <= 1'b0;
            rst_n  <= 1'b0;
        end else begin
            rst_q1 <= 1'b1;
            rst_n  <= rst_q1;
        end
    end

    // ----------------------------------------
    // Address mapping
    // ----------------------------------------
    // Split mode pins each port to one half of the array
    function automatic logic [IDX_W-1:0] map_idx(
        input logic [dprm_pkg::ADDR_W-1:0] addr,
        input logic                        port_b,
        input dprm_pkg::dprm_mode_t        md
    );
        logic [IDX_W-1:0] idx;
        idx = addr[IDX_W-1:0];
        if (md == dprm_pkg::MODE_SP2) begin
            idx[IDX_W-1] = port_b;
        end
        return idx;
    endfunction : map_idx

    logic [IDX_W-1:0] idx [2];

    assign idx[0] = map_idx({a_addr_hi, a_addr_lo}, 1'b0, mode);
    assign idx[1] = map_idx({b_addr_hi, b_addr_lo}, 1'b1, mode);

    // ----------------------------------------
    // Clock scheme selection
    // ----------------------------------------
    logic [1:0] clk1, en1, clr1, clk2, en2, clr2;
    logic [1:0] in_go, out_go, clr_in, clr_out, use_rden, can_wr;

    assign clk1 = {b_clk, a_clk};
    assign en1  = {b_clken, a_clken};
    assign clr1 = {b_clr, a_clr};
    assign clk2 = {b_clk2, a_clk2};
    assign en2  = {b_clken2, a_clken2};
    assign clr2 = {b_clr2, a_clr2};

    always_comb begin
        in_go    = clk1 & en1;
        out_go   = clk1 & en1;
        clr_in   = clr1;
        clr_out  = clr1;
        use_rden = 2'b00;
        can_wr   = 2'b11;
        case (mode)
            dprm_pkg::MODE_IND, dprm_pkg::MODE_SP2: begin
            end
            dprm_pkg::MODE_IO_TDP: begin
                out_go  = clk2 & en2;
                clr_out = clr2;
            end
            dprm_pkg::MODE_IO_SDP: begin
                out_go   = clk2 & en2;
                clr_out  = clr2;
                use_rden = 2'b10;
                can_wr   = 2'b01;
            end
            dprm_pkg::MODE_RW: begin
                use_rden = 2'b10;
                can_wr   = 2'b01;
            end
            dprm_pkg::MODE_SP: begin
                in_go[1]   = 1'b0;
                out_go[1]  = 1'b0;
                clr_in[1]  = 1'b1;
                clr_out[1] = 1'b1;
            end
            default: begin
                in_go  = 2'b00;
                out_go = 2'b00;
            end
        endcase
    end

    // ----------------------------------------
    // Port register groups
    // ----------------------------------------
    logic [dprm_pkg::DATA_W-1:0] mem [MEM_DEPTH];
    logic [dprm_pkg::DATA_W-1:0] next_mem [MEM_DEPTH];
    logic [IDX_W-1:0]            wr_idx [2];
    logic [dprm_pkg::MASK_W-1:0] wr_lanes [2];
    logic [dprm_pkg::DATA_W-1:0] wr_data [2];

    dprm_port #(.IDX_W(IDX_W)) u_port_a (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .in_go    (in_go[0]),
        .out_go   (out_go[0]),
        .clr_in   (clr_in[0]),
        .clr_out  (clr_out[0]),
        .bypass   (a_bypass),
        .use_rden (use_rden[0]),
        .can_wr   (can_wr[0]),
        .idx      (idx[0]),
        .wsel     (a_wsel),
        .mask     (a_byte_mask),
        .din      (a_din),
        .rden     (1'b1),
        .dout     (a_dout),
        .mem_word (mem[wr_idx[0]]),
        .wr_idx   (wr_idx[0]),
        .wr_lanes (wr_lanes[0]),
        .wr_data  (wr_data[0])
    );

    dprm_port #(.IDX_W(IDX_W)) u_port_b (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .ce       (ce),
        .in_go    (in_go[1]),
        .out_go   (out_go[1]),
        .clr_in   (clr_in[1]),
        .clr_out  (clr_out[1]),
        .bypass   (b_bypass),
        .use_rden (use_rden[1]),
        .can_wr   (can_wr[1]),
        .idx      (idx[1]),
        .wsel     (b_wsel),
        .mask     (b_byte_mask),
        .din      (b_din),
        .rden     (b_rden),
        .dout     (b_dout),
        .mem_word (mem[wr_idx[1]]),
        .wr_idx   (wr_idx[1]),
        .wr_lanes (wr_lanes[1]),
        .wr_data  (wr_data[1])
    );

    // ----------------------------------------
    // Array write, lane by lane
    // ----------------------------------------
    // Port A is applied last, so it wins a same-word collision
    always_comb begin
        next_mem = mem;
        for (int p = 1; p >= 0; p--) begin
            for (int l = 0; l < dprm_pkg::MASK_W; l++) begin
                if (wr_lanes[p][l]) begin
                    next_mem[wr_idx[p]][l*dprm_pkg::LANE_W +: dprm_pkg::LANE_W] =
                        wr_data[p][l*dprm_pkg::LANE_W +: dprm_pkg::LANE_W];
                end
            end
        end
    end

    // Array has no reset; clears only block writes, never wipe it
    always_ff @(posedge mclk) begin
        if (ce) begin
            mem <= next_mem;
        end
    end

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    chk_lane_written: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && wr_lanes[0][0]) |=>
        mem[$past(wr_idx[0])][dprm_pkg::LANE_W-1:0] == $past(wr_data[0][8:0]))
        else $error("masked lane not written");

    // Watched only on a real partial write: unwritten words hold unknowns
    chk_lane_kept: assert property (@(posedge mclk) disable iff (!rst_n)
        (ce && wr_lanes[0] != '0 && !wr_lanes[0][7] && !wr_lanes[1][7]) |=>
        mem[$past(wr_idx[0])][71:63] == $past(mem[wr_idx[0]][71:63]))
        else $error("unmasked lane changed");

    chk_rw_read_clock: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode == dprm_pkg::MODE_RW) |->
        (in_go[1] == (b_clk && b_clken)) && (out_go[1] == in_go[1]))
        else $error("read side not on read clock");

    chk_rw_no_b_write: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode == dprm_pkg::MODE_RW) |-> wr_lanes[1] == '0)
        else $error("read port wrote in simple dual-port");

    chk_io_split: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode == dprm_pkg::MODE_IO_TDP) |->
        (out_go[0] == (a_clk2 && a_clken2)) && (clr_out[0] == a_clr2))
        else $error("output group not on second clock");

    chk_sp_b_quiet: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode == dprm_pkg::MODE_SP) [*2] |-> b_dout == dprm_pkg::DATA_RST)
        else $error("port B active in single-port mode");

    chk_sp2_halves: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode == dprm_pkg::MODE_SP2 && ce && in_go[1]) |=>
        wr_idx[1][IDX_W-1] && !wr_idx[0][IDX_W-1] || !$stable(mode))
        else $error("split memories overlap");

    chk_ind_own_clock: assert property (@(posedge mclk) disable iff (!rst_n)
        (mode == dprm_pkg::MODE_IND) |-> in_go == (clk1 & en1) && out_go == in_go)
        else $error("independent clocks crossed");

endmodule : dprm_ram

// ==== tb/dprm_fab.sv ====
module dprm_fab (
    // Clock
    input  wire logic                        mclk,
    // User side of one port
    output logic                             clk,
    output logic                             wsel,
    output logic [dprm_pkg::ADDR_GRP_W-1:0]  addr_hi,
    output logic [dprm_pkg::ADDR_GRP_W-1:0]  addr_lo,
    output logic [dprm_pkg::MASK_W-1:0]      byte_mask,
    output logic [dprm_pkg::DATA_W-1:0]      din
);
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Idle levels
    // ----------------------------------------
    initial begin
        clk       = 1'b0;
        wsel      = 1'b0;
        addr_hi   = 8'h00;
        addr_lo   = 8'h00;
        byte_mask = dprm_pkg::MASK_RST;
        din       = dprm_pkg::DATA_RST;
    end

    // ----------------------------------------
    // One tick on the port clock
    // ----------------------------------------
    // Gap gives slow callers; lines are inverted between ticks so that a
    // design sampling off the tick sees garbage, not the last value
    task automatic op(input logic                        wr,
                      input logic [dprm_pkg::ADDR_W-1:0] addr,
                      input logic [dprm_pkg::MASK_W-1:0] m,
                      input logic [dprm_pkg::DATA_W-1:0] d,
                      input int                          gap);
        repeat (gap) @(posedge mclk);
        @(posedge mclk);
        clk                <= 1'b1;
        wsel               <= wr;
        {addr_hi, addr_lo} <= addr;
        byte_mask          <= m;
        din                <= d;
        @(posedge mclk);
        clk                <= 1'b0;
        wsel               <= ~wr;
        {addr_hi, addr_lo} <= ~addr;
        byte_mask          <= ~m;
        din                <= ~d;
    endtask : op

endmodule : dprm_fab

// ==== tb/tb.sv ====
module tb;
    timeunit 1ns;
    timeprecision 1ps;

    // ----------------------------------------
    // Signals
    // ----------------------------------------
    localparam logic [71:0] D1  = 72'h12_3456_789a_bcde_f012;
    localparam logic [71:0] D2  = 72'hab_cdef_0123_4567_89ab;
    localparam logic [71:0] D3  = 72'h5a_5a5a_a5a5_0f0f_f0f0;
    localparam logic [71:0] ONE = 72'hff_ffff_ffff_ffff_ffff;
    localparam logic [71:0] MSK = 72'hff_ffff_fff0_0000_0000;
    localparam logic [71:0] ZRO = 72'h00_0000_0000_0000_0000;
    logic                        mclk, resetn, ce, b_rden;
    dprm_pkg::dprm_mode_t        mode;
    logic                        a_clken, a_clr, a_clk2, a_clken2, a_clr2, a_bypass;
    logic                        b_clken, b_clr, b_clk2, b_clken2, b_clr2, b_bypass;
    logic                        a_clk, a_wsel, b_clk, b_wsel;
    logic [7:0]                  a_hi, a_lo, a_mask, b_hi, b_lo, b_mask;
    logic [71:0]                 a_din, a_dout, b_din, b_dout;
    int                          errors, comparisons, cycles;

    dprm_fab fab_a (.mclk(mclk), .clk(a_clk), .wsel(a_wsel), .addr_hi(a_hi),
                    .addr_lo(a_lo), .byte_mask(a_mask), .din(a_din));
    dprm_fab fab_b (.mclk(mclk), .clk(b_clk), .wsel(b_wsel), .addr_hi(b_hi),
                    .addr_lo(b_lo), .byte_mask(b_mask), .din(b_din));

    dprm_ram #(.MEM_DEPTH(16)) i_dprm_ram (
        .mclk(mclk), .resetn(resetn), .ce(ce), .mode(mode),
        .a_clk(a_clk), .a_clken(a_clken), .a_clr(a_clr), .a_clk2(a_clk2),
        .a_clken2(a_clken2), .a_clr2(a_clr2), .a_bypass(a_bypass),
        .a_addr_hi(a_hi), .a_addr_lo(a_lo), .a_byte_mask(a_mask), .a_wsel(a_wsel),
        .a_din(a_din), .a_dout(a_dout),
        .b_clk(b_clk), .b_clken(b_clken), .b_clr(b_clr), .b_clk2(b_clk2),
        .b_clken2(b_clken2), .b_clr2(b_clr2), .b_bypass(b_bypass),
        .b_addr_hi(b_hi), .b_addr_lo(b_lo), .b_byte_mask(b_mask), .b_wsel(b_wsel),
        .b_rden(b_rden), .b_din(b_din), .b_dout(b_dout));

    // ----------------------------------------
    // Clock, watchdog, helpers
    // ----------------------------------------
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    // Whole run is under two hundred cycles; the ceiling leaves wide margin
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            errors++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("errors=%0d comparisons=%0d", errors, comparisons);
        if (errors == 0 && comparisons > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        comparisons++;
        if (got !== exp) begin
            errors++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic settle(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : settle

    // Mode is a static level, so it only changes under reset
    task automatic reboot(input dprm_pkg::dprm_mode_t m, input logic byp);
        @(posedge mclk);
        resetn   <= 1'b0;
        mode     <= m;
        a_bypass <= byp;
        b_bypass <= byp;
        repeat (2) @(posedge mclk);
        resetn   <= 1'b1;
        repeat (4) @(posedge mclk);
    endtask : reboot

    task automatic pulse2(input logic en);
        @(posedge mclk);
        a_clken2 <= en;
        a_clk2   <= 1'b1;
        @(posedge mclk);
        a_clk2   <= 1'b0;
        settle(2);
    endtask : pulse2

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_ind();
        reboot(dprm_pkg::MODE_IND, 1'b1);
        fork
            fab_a.op(1'b1, 16'h0003, 8'hff, D1, 0);
            fab_b.op(1'b1, 16'h0005, 8'hff, D2, 0);
        join
        fork
            fab_a.op(1'b0, 16'h0005, 8'hff, ZRO, 0);
            fab_b.op(1'b0, 16'h0003, 8'hff, ONE, 3);
        join
        settle(3);
        chk(a_dout, D2);
        chk(b_dout, D1);
    endtask : t_ind

    task automatic t_mask();
        fab_a.op(1'b1, 16'h0007, 8'hff, ONE, 0);
        fab_a.op(1'b1, 16'h0007, 8'h0f, ZRO, 0);
        fab_a.op(1'b1, 16'h0007, 8'h00, ZRO, 0);
        fab_a.op(1'b0, 16'h0007, 8'hff, ZRO, 0);
        settle(3);
        chk(a_dout, MSK);
    endtask : t_mask

    task automatic t_clr_ce();
        @(posedge mclk);
        a_clr <= 1'b1;
        settle(1);
        chk(a_dout, ZRO);
        chk(b_dout, D1);
        @(posedge mclk);
        a_clr   <= 1'b0;
        a_clken <= 1'b0;
        fab_a.op(1'b1, 16'h0007, 8'hff, ZRO, 0);
        a_clken <= 1'b1;
        ce      <= 1'b0;
        fab_b.op(1'b1, 16'h0007, 8'hff, D3, 0);
        ce      <= 1'b1;
        fab_a.op(1'b0, 16'h0007, 8'hff, ZRO, 0);
        settle(3);
        chk(a_dout, MSK);
    endtask : t_clr_ce

    task automatic t_nobyp();
        reboot(dprm_pkg::MODE_IND, 1'b0);
        // Word already holds known data, so the output register never loads unknowns
        fab_a.op(1'b1, 16'h0007, 8'hff, D3, 0);
        fab_a.op(1'b0, 16'h0007, 8'hff, ZRO, 0);
        fab_a.op(1'b0, 16'h0007, 8'hff, ZRO, 0);
        settle(3);
        chk(a_dout, D3);
    endtask : t_nobyp

    task automatic t_rw();
        reboot(dprm_pkg::MODE_RW, 1'b1);
        @(posedge mclk);
        b_rden <= 1'b1;
        fab_a.op(1'b1, 16'h0004, 8'hff, D1, 0);
        fab_b.op(1'b0, 16'h0004, 8'hff, ZRO, 0);
        settle(3);
        chk(b_dout, D1);
        fab_b.op(1'b1, 16'h0004, 8'hff, D2, 0);
        fab_a.op(1'b1, 16'h0006, 8'hff, D3, 0);
        b_rden <= 1'b0;
        fab_b.op(1'b0, 16'h0006, 8'hff, ZRO, 0);
        settle(3);
        chk(b_dout, D1);
        @(posedge mclk);
        b_rden <= 1'b1;
        fab_b.op(1'b0, 16'h0004, 8'hff, ZRO, 0);
        settle(3);
        chk(b_dout, D1);
        @(posedge mclk);
        b_clr <= 1'b1;
        settle(1);
        chk(b_dout, ZRO);
        @(posedge mclk);
        b_clr <= 1'b0;
    endtask : t_rw

    task automatic t_io();
        reboot(dprm_pkg::MODE_IO_TDP, 1'b0);
        fab_a.op(1'b1, 16'h0008, 8'hff, D2, 0);
        fab_a.op(1'b0, 16'h0008, 8'hff, ZRO, 0);
        settle(3);
        pulse2(1'b0);
        chk(a_dout, ZRO);
        pulse2(1'b1);
        chk(a_dout, D2);
        @(posedge mclk);
        a_clr <= 1'b1;
        settle(2);
        chk(a_dout, D2);
        @(posedge mclk);
        a_clr  <= 1'b0;
        a_clr2 <= 1'b1;
        settle(1);
        chk(a_dout, ZRO);
        @(posedge mclk);
        a_clr2 <= 1'b0;
        // Simple dual-port: B write refused, B read lands on its second clock
        reboot(dprm_pkg::MODE_IO_SDP, 1'b0);
        fab_a.op(1'b1, 16'h0008, 8'hff, D3, 0);
        fab_b.op(1'b1, 16'h0008, 8'hff, D1, 0);
        fab_b.op(1'b0, 16'h0008, 8'hff, ZRO, 0);
        @(posedge mclk);
        b_clk2 <= 1'b1;
        @(posedge mclk);
        b_clk2 <= 1'b0;
        settle(2);
        chk(b_dout, D3);
    endtask : t_io

    task automatic t_sp();
        reboot(dprm_pkg::MODE_SP, 1'b1);
        fab_a.op(1'b1, 16'h0009, 8'hff, D3, 0);
        fab_b.op(1'b1, 16'h0009, 8'hff, D1, 0);
        fab_a.op(1'b0, 16'h0009, 8'hff, ZRO, 0);
        fab_b.op(1'b0, 16'h0009, 8'hff, ZRO, 0);
        settle(3);
        chk(a_dout, D3);
        chk(b_dout, ZRO);
        reboot(dprm_pkg::MODE_SP2, 1'b1);
        fork
            fab_a.op(1'b1, 16'h0001, 8'hff, D1, 0);
            fab_b.op(1'b1, 16'h0001, 8'hff, D2, 1);
        join
        fork
            fab_a.op(1'b0, 16'h0001, 8'hff, ZRO, 0);
            fab_b.op(1'b0, 16'h0001, 8'hff, ZRO, 0);
        join
        settle(3);
        chk(a_dout, D1);
        chk(b_dout, D2);
    endtask : t_sp

    // ----------------------------------------
    // Main sequence
    // ----------------------------------------
    initial begin
        errors      = 0;
        comparisons = 0;
        cycles      = 0;
        resetn      = 1'b0;
        ce          = 1'b1;
        mode        = dprm_pkg::MODE_IND;
        b_rden      = 1'b0;
        {a_clken, a_clr, a_clk2, a_clken2, a_clr2, a_bypass} = 6'b100_101;
        {b_clken, b_clr, b_clk2, b_clken2, b_clr2, b_bypass} = 6'b100_101;
        repeat (12) @(posedge mclk);
        resetn <= 1'b1;
        t_ind();
        t_mask();
        t_clr_ce();
        t_nobyp();
        t_rw();
        t_io();
        t_sp();
        tally_and_finish();
    end

endmodule : tb
